// >>> rtl/ienc_pkg.sv
// Purpose: shared constants and types for the incremental encoder counter
// Assumes: pclk at 40 MHz
// Notes:   apb offsets are byte addresses

package ienc_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned FREQ_WIN_MS     = 10;
  localparam int unsigned PERIOD_TICK_NS  = 500;
  localparam int unsigned IDLE_TIMEOUT_MS = 1600;
  localparam int unsigned WIN_TICK_US     = 16;

  localparam int unsigned FREQ_WIN_CYC  = CLK_HZ / 1000 * FREQ_WIN_MS;
  localparam int unsigned PERIOD_CYC    = CLK_HZ / 1000 * PERIOD_TICK_NS
                                          / 1_000_000;
  localparam int unsigned IDLE_CYC      = CLK_HZ / 1000 * IDLE_TIMEOUT_MS;
  localparam int unsigned WIN_TICK_CYC  = CLK_HZ / 1_000_000 * WIN_TICK_US;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RELOAD  = 8'h04;
  localparam logic [7:0] OFS_WINLEN  = 8'h08;
  localparam logic [7:0] OFS_POS     = 8'h0c;
  localparam logic [7:0] OFS_LATCH   = 8'h10;
  localparam logic [7:0] OFS_FREQ    = 8'h14;
  localparam logic [7:0] OFS_PERWIN  = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_CYCLIC0 = 8'h20;
  localparam logic [7:0] OFS_CYCLIC1 = 8'h24;
  localparam logic [7:0] OFS_ALSTATE = 8'h28;

  // ctrl field positions; the reinit bit is taken from alstate writes
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_LATCH    = 4;
  localparam int unsigned CTRL_REINIT   = 5;

  localparam logic [2:0]  MODE_RST     = 3'h1;
  localparam logic [15:0] RELOAD_RST   = 16'hffff;
  localparam logic [15:0] WINLEN_RST   = 16'h0001;

  typedef enum logic [3:0] {
    IENC_INIT   = 4'b0001,
    IENC_PREOP  = 4'b0010,
    IENC_SAFEOP = 4'b0100,
    IENC_OP     = 4'b1000
  } ienc_al_type;

  typedef struct packed {
    logic trk_a;
    logic trk_b;
    logic trk_c;
    logic gate;
  } ienc_tracks_type;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] period;
    logic [15:0] window;
  } ienc_meas_type;

endpackage

// >>> rtl/ienc_counter.sv
// Purpose: incremental encoder counter, normal free-running mode, apb slave
// Assumes: encoder tracks already synchronous to pclk
// Notes:   one clock domain, no distributed-clock functions
//
// Overview of operation
// [R1] frequency is increments per fixed 10 ms
// [R2] period between rising A edges, 500 ns units
// [R3] 1.6 s without increments zeroes frequency, period
// [R4] window count over user length, 16 us units
// [R5] frequency 32 bits, period and window 16
// [R6] position and latch are 16 bits
// [R7] byte alignment default, word alignment optional
// [R8] six modes: alignment times one feature
// [R9] controller uses only listed mode combinations
// [R10] free running on internal timebase only
// [R11] power-up steps INIT, PREOP, SAFEOP, OP
// [R12] controller reinitialises after changing mode
// [R13] reload wraps to zero, underflow loads value
// [R14] track C clears counter, not with reload
// [R15] forward count: A edges, B gives direction
// [R16] gate edge locks counter, edge selectable
// [R17] without reload, wrap modulo 65536
//
// Register access over APB and the register offsets were decided locally.

`timescale 1ns/1ps
`default_nettype none

module ienc_counter (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire ienc_pkg::ienc_tracks_type tracks,
  output ienc_pkg::ienc_meas_type        meas,
  output logic      [15:0]               position,
  output logic      [15:0]               latch_pos
);

  // mode code: 1..6; 1-3 byte aligned, 4-6 word aligned
  function automatic logic [1:0] feat_of(input logic [2:0] m);
    feat_of = (m > 3'h3) ? 2'(m - 3'h3) : m[1:0];
  endfunction

  logic [2:0]  mode_wr_r;
  logic [2:0]  mode_r;
  logic        latch_en_r;
  logic [15:0] reload_r;
  logic [15:0] winlen_r;
  logic [1:0]  gate_sel_r;
  logic [15:0] pos_r;
  logic [15:0] latch_r;
  logic        a_d_r;
  logic        c_d_r;
  logic        g_d_r;
  logic        locked_r;
  ienc_pkg::ienc_al_type al_r;
  logic [31:0] fcnt_r;
  logic [31:0] ftmr_r;
  logic [31:0] freq_r;
  logic [31:0] pcnt_r;
  logic [7:0]  ptick_r;
  logic [15:0] period_r;
  logic        a_seen_r;
  logic [31:0] idle_r;
  logic [15:0] wcnt_r;
  logic [15:0] wtick_r;
  logic [15:0] wlen_cnt_r;
  logic [15:0] window_r;
  logic [31:0] prdata_r;
  logic        rd_done_r;

  wire        wr_acc     = psel && penable && pwrite;
  wire        rd_acc     = psel && penable && !pwrite;
  wire [1:0]  feat       = feat_of(mode_r);
  wire        word_align = (mode_r > 3'h3);                          // R7
  wire        f_reload   = (feat == 2'h1);                           // R8
  wire        f_index    = (feat == 2'h2);                           // R14
  wire        f_fwd      = (feat == 2'h3);
  wire        run        = (al_r == ienc_pkg::IENC_OP);
  wire        a_rise     = tracks.trk_a && !a_d_r;
  wire        a_edge     = tracks.trk_a ^ a_d_r;
  wire        c_rise     = tracks.trk_c && !c_d_r;
  wire        g_rise     = tracks.gate && !g_d_r;
  wire        g_fall     = !tracks.gate && g_d_r;
  // quadrature decode: each A edge, direction from B relative to A
  wire        quad_up    = tracks.trk_a ^ tracks.trk_b;
  wire        fwd_step   = a_edge && !locked_r;                      // R15
  wire        q_step     = a_edge;
  wire        step       = run && (f_fwd ? fwd_step : q_step);
  wire        up         = f_fwd ? tracks.trk_b : quad_up;           // R15
  wire        idle_hit   = (idle_r >= ienc_pkg::IDLE_CYC - 1);
  wire        ftmr_hit   = (ftmr_r == ienc_pkg::FREQ_WIN_CYC - 1);

  // write strobes, one per writable register
  wire        wr_ctrl    = wr_acc && (paddr == ienc_pkg::OFS_CTRL);
  wire        wr_reload  = wr_acc && (paddr == ienc_pkg::OFS_RELOAD);
  wire        wr_winlen  = wr_acc && (paddr == ienc_pkg::OFS_WINLEN);

  // position next value
  logic [15:0] pos_nxt;
  always_comb begin
    pos_nxt = pos_r;
    // an index clear outranks a count step in the same cycle
    if (run && f_index && c_rise) begin
      pos_nxt = 16'h0000;                                            // R14
    end else if (step && up) begin
      if (f_reload && pos_r >= reload_r)
        pos_nxt = 16'h0000;                                          // R13
      else
        pos_nxt = pos_r + 16'h0001;                                  // R17
    end else if (step) begin
      if (f_reload && pos_r == 16'h0000)
        pos_nxt = reload_r;                                          // R13
      else
        pos_nxt = pos_r - 16'h0001;                                  // R17
    end
  end

  // apb slave: writes finish at once; reads take one wait state so that
  // prdata is a flip-flop already holding the word at the completing edge
  assign pready  = !rd_acc || rd_done_r;
  assign pslverr = 1'b0;
  assign prdata  = prdata_r;

  // cyclic image: status byte, position, latch; byte mode packs them back
  // to back, word mode pads the status byte out to 16 bits
  wire [7:0]  stat8 = {4'h0, locked_r, 3'(feat)};
  wire [31:0] cyc0  = word_align ? {pos_r, 8'h00, stat8}             // R7
                                 : {latch_r[7:0], pos_r, stat8};
  wire [31:0] cyc1  = word_align ? {16'h0000, latch_r}
                                 : {24'h00_0000, latch_r[15:8]};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr)
      ienc_pkg::OFS_CTRL:    rd_mux = {24'h0, 2'h0, gate_sel_r,
                                       1'b0, mode_wr_r};
      ienc_pkg::OFS_RELOAD:  rd_mux = {16'h0, reload_r};
      ienc_pkg::OFS_WINLEN:  rd_mux = {16'h0, winlen_r};
      ienc_pkg::OFS_POS:     rd_mux = {16'h0, pos_r};                // R6
      ienc_pkg::OFS_LATCH:   rd_mux = {16'h0, latch_r};
      ienc_pkg::OFS_FREQ:    rd_mux = freq_r;                        // R5
      ienc_pkg::OFS_PERWIN:  rd_mux = {period_r, window_r};
      ienc_pkg::OFS_STATUS:  rd_mux = {24'h0, stat8};
      ienc_pkg::OFS_CYCLIC0: rd_mux = cyc0;
      ienc_pkg::OFS_CYCLIC1: rd_mux = cyc1;
      ienc_pkg::OFS_ALSTATE: rd_mux = {28'h0, al_r};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r   <= 32'h0000_0000;
      rd_done_r  <= 1'b0;
      mode_wr_r  <= ienc_pkg::MODE_RST;
      gate_sel_r <= 2'h0;
      reload_r   <= ienc_pkg::RELOAD_RST;
      winlen_r   <= ienc_pkg::WINLEN_RST;
    end else begin
      rd_done_r <= rd_acc && !rd_done_r;
      if (rd_acc && !rd_done_r)
        prdata_r <= rd_mux;
      // mode stays staged until reinit, so a half-set mode never runs
      if (wr_ctrl) begin
        mode_wr_r  <= pwdata[2:0];
        gate_sel_r <= pwdata[5:4];
      end
      if (wr_reload)
        reload_r <= pwdata[15:0];
      if (wr_winlen)
        winlen_r <= pwdata[15:0];
    end
  end

  // bus-master directed state steps; mode applies on reinit only
  wire ctl_wr   = wr_acc && paddr == ienc_pkg::OFS_ALSTATE;
  wire reinit   = ctl_wr && pwdata[ienc_pkg::CTRL_REINIT];
  wire latch_rq = wr_acc && paddr == ienc_pkg::OFS_CTRL
                  && pwdata[ienc_pkg::CTRL_LATCH];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_r   <= ienc_pkg::IENC_INIT;
      mode_r <= ienc_pkg::MODE_RST;
    end else if (reinit) begin
      al_r   <= ienc_pkg::IENC_INIT;                                 // R12
      mode_r <= mode_wr_r;
    end else if (ctl_wr && pwdata[0]) begin
      unique case (al_r)                                             // R11
        ienc_pkg::IENC_INIT:   al_r <= ienc_pkg::IENC_PREOP;
        ienc_pkg::IENC_PREOP:  al_r <= ienc_pkg::IENC_SAFEOP;
        ienc_pkg::IENC_SAFEOP: al_r <= ienc_pkg::IENC_OP;
        ienc_pkg::IENC_OP:     al_r <= ienc_pkg::IENC_OP;
        default:               al_r <= ienc_pkg::IENC_INIT;
      endcase
    end
  end

  // counter, latch, gate lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r      <= 16'h0000;
      latch_r    <= 16'h0000;
      latch_en_r <= 1'b0;
      a_d_r      <= 1'b0;
      c_d_r      <= 1'b0;
      g_d_r      <= 1'b0;
      locked_r   <= 1'b0;
    end else begin
      a_d_r      <= tracks.trk_a;
      c_d_r      <= tracks.trk_c;
      g_d_r      <= tracks.gate;
      pos_r      <= pos_nxt;
      latch_en_r <= latch_rq;
      if (latch_en_r)
        latch_r <= pos_r;
      // each chosen gate edge toggles the lock, the next one frees it
      if (f_fwd && ((gate_sel_r[0] && g_rise) || (gate_sel_r[1] && g_fall)))
        locked_r <= !locked_r;                                       // R16
      else if (!f_fwd)
        locked_r <= 1'b0;
    end
  end

  // measurements on the internal timebase only (R10)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_r   <= 32'h0;
      ftmr_r   <= 32'h0;
      freq_r   <= 32'h0;
      pcnt_r   <= 32'h0;
      ptick_r  <= 8'h0;
      period_r <= 16'h0;
      a_seen_r <= 1'b0;
      idle_r   <= 32'h0;
    end else begin
      ftmr_r <= ftmr_hit ? 32'h0 : ftmr_r + 32'h1;                  // R10
      if (ftmr_hit) begin
        freq_r <= fcnt_r + {31'h0, step};                           // R1
        fcnt_r <= 32'h0;
      end else if (step) begin
        fcnt_r <= fcnt_r + 32'h1;
      end
      ptick_r <= (ptick_r == 8'(ienc_pkg::PERIOD_CYC - 1)) ? 8'h0
                 : ptick_r + 8'h1;
      if (a_rise) begin
        // saturates rather than wraps, so a slow axis never reads as fast
        if (a_seen_r)
          period_r <= (pcnt_r > 32'hffff) ? 16'hffff : pcnt_r[15:0];  // R2
        a_seen_r <= 1'b1;
        pcnt_r   <= 32'h0;
      end else if (ptick_r == 8'(ienc_pkg::PERIOD_CYC - 1)) begin
        pcnt_r <= pcnt_r + 32'h1;
      end
      idle_r <= a_edge ? 32'h0 : (idle_hit ? idle_r : idle_r + 32'h1);
      // a fresh edge wins over the idle clear, so it still starts a period
      if (idle_hit && !a_edge) begin
        freq_r   <= 32'h0;                                          // R3
        period_r <= 16'h0;
        a_seen_r <= 1'b0;
      end
    end
  end

  // user window count in 16 us ticks
  // a length of zero runs 65536 ticks, as the end compare wraps
  wire wtick_hit = (wtick_r == 16'(ienc_pkg::WIN_TICK_CYC - 1));
  wire wend      = wtick_hit && (wlen_cnt_r >= winlen_r - 16'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_r     <= 16'h0;
      wtick_r    <= 16'h0;
      wlen_cnt_r <= 16'h0;
      window_r   <= 16'h0;
    end else begin
      wtick_r <= wtick_hit ? 16'h0 : wtick_r + 16'h1;
      if (wend) begin
        window_r   <= wcnt_r + {15'h0, step};                        // R4
        wcnt_r     <= 16'h0;
        wlen_cnt_r <= 16'h0;
      end else begin
        if (wtick_hit)
          wlen_cnt_r <= wlen_cnt_r + 16'h1;
        if (step)
          wcnt_r <= wcnt_r + 16'h1;
      end
    end
  end

  // every output below is a plain register copy
  assign meas      = '{freq: freq_r, period: period_r, window: window_r};
  assign position  = pos_r;
  assign latch_pos = latch_r;

endmodule

`default_nettype wire

// >>> testbench/ienc_encoder_model.sv
// Purpose: encoder stand-in driving a, b, c tracks and the gate input
// Assumes: one step request gives exactly one edge of track a
// Notes:   b settles a cycle before a moves, never on the same edge
`timescale 1ns/1ps
`default_nettype none
module ienc_encoder_model (
  input  wire logic                pclk,
  input  wire logic                step,
  input  wire logic                up,
  input  wire logic                fwd,
  input  wire logic                idx,
  input  wire logic                gate,
  output ienc_pkg::ienc_tracks_type tracks
);
  logic a_r    = 1'b0;
  logic b_r    = 1'b0;
  logic pend_r = 1'b0;
  always_ff @(posedge pclk) begin
    if (step) begin
      b_r    <= fwd ? up : (up ? a_r : ~a_r);
      pend_r <= 1'b1;
    end else if (pend_r) begin
      a_r    <= ~a_r;
      pend_r <= 1'b0;
    end
  end
  assign tracks = {a_r, b_r, idx, gate};
endmodule
`default_nettype wire

// >>> testbench/ienc_counter_assertions.sv
// Purpose: port-level checks of the encoder counter
// Assumes: writes answered at once, reads after one wait state
// Notes:   helper counters bound how late an output may react
`timescale 1ns/1ps
`default_nettype none
module ienc_counter_assertions (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire ienc_pkg::ienc_tracks_type tracks,
  input wire ienc_pkg::ienc_meas_type   meas,
  input wire logic [15:0]               position,
  input wire logic [15:0]               latch_pos
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       acc    = psel && penable;
  wire       rd_acc = acc && !pwrite;
  wire       wr_acc = acc && pwrite;
  logic [1:0] quiet_r;
  logic [2:0] wr_age_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_r  <= 2'h0;
      wr_age_r <= 3'h0;
    end else begin
      quiet_r  <= ($changed(tracks.trk_a) || tracks.trk_c || psel) ? 2'h0
                  : quiet_r + {1'b0, quiet_r != 2'h3};
      wr_age_r <= wr_acc ? 3'h0 : wr_age_r + {2'h0, wr_age_r != 3'h7};
    end
  end
  zero_wait_a: assert property (wr_acc |-> pready && !pslverr)
    else $error("apb write not answered at once");
  read_wait_a: assert property (rd_acc && !$past(acc) |->
    !pready ##1 pready && !pslverr)
    else $error("apb read not answered after one wait");
  pos_quiet_a: assert property (quiet_r == 2'h3 |-> $stable(position))
    else $error("position moved without a track a edge");
  latch_hold_a: assert property ($changed(latch_pos) |-> wr_age_r < 3'h4)
    else $error("latch moved without a write");
  latch_copy_a: assert property (wr_acc && paddr == ienc_pkg::OFS_CTRL &&
    pwdata[4] ##1 $stable(position)[*3] |-> latch_pos == position)
    else $error("latch did not take the position");
  unmapped_a: assert property (rd_acc && pready && paddr > 8'h2b
    |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  state_hot_a: assert property (rd_acc && pready
    && paddr == ienc_pkg::OFS_ALSTATE
    |-> $onehot(prdata[3:0]) && prdata[31:4] == 28'h0)
    else $error("state read not one-hot");
  reload_rw_a: assert property (wr_acc && paddr == ienc_pkg::OFS_RELOAD ##4
    rd_acc && pready && paddr == ienc_pkg::OFS_RELOAD
    |-> prdata[15:0] == $past(pwdata[15:0], 4))
    else $error("reload value not read back");
  cover property (wr_acc && paddr == ienc_pkg::OFS_RELOAD ##4
    rd_acc && pready);
  cover property (tracks.trk_c ##2 position == 16'h0);
  cover property ($changed(meas.period));
endmodule
bind ienc_counter ienc_counter_assertions u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tracks(tracks), .meas(meas), .position(position),
  .latch_pos(latch_pos));
`default_nettype wire

// >>> testbench/ienc_counter_tb.sv
// Purpose: directed apb and encoder sequences with expected values
// Assumes: read data taken while pready stands high
// Notes:   10 ms and 1.6 s counts are too long to run here
`timescale 1ns/1ps
`default_nettype none
module ienc_counter_tb;
  logic                      pclk = 0, presetn = 0, step = 0, up = 1;
  logic                      psel = 0, penable = 0, pwrite = 0;
  logic                      fwd = 0, idx = 0, gate = 0;
  logic                      pready, pslverr;
  logic [7:0]                paddr = 0;
  logic [31:0]               pwdata = 0, prdata, rd;
  logic [15:0]               position, latch_pos, p;
  ienc_pkg::ienc_tracks_type tracks;
  ienc_pkg::ienc_meas_type   meas;
  int                        fail_count = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  ienc_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tracks(tracks),
    .meas(meas), .position(position), .latch_pos(latch_pos));
  ienc_encoder_model u_enc (.pclk(pclk), .step(step), .up(up), .fwd(fwd),
    .idx(idx), .gate(gate), .tracks(tracks));
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g, int tol = 0);
    n_checks++;
    if ((^g) === 1'bx || g > e + tol || g + tol < e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(negedge pclk) rd = prdata;
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge pclk) begin
      psel <= 0;
      penable <= 0;
    end
    @(posedge pclk);
  endtask
  task automatic mv(int n, logic u, int g = 4);
    repeat (n) begin
      up <= u; step <= 1;
      @(posedge pclk) step <= 0;
      repeat (g) @(posedge pclk);
    end
  endtask
  // mode only takes effect after reinit, then the walk back to op
  task automatic remode(logic [31:0] m);
    apb(1, ienc_pkg::OFS_CTRL, m);
    apb(1, ienc_pkg::OFS_ALSTATE, 32'h20);
    repeat (3) apb(1, ienc_pkg::OFS_ALSTATE, 32'h1);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ienc_pkg::OFS_CTRL, 0);
    chk("mode", 32'h1, rd & 32'h7);
    apb(0, ienc_pkg::OFS_WINLEN, 0);
    chk("winlen", 32'h1, rd);
    apb(0, 8'h2c, 0);
    chk("unmapped", 32'h0, rd);
    for (int m = 6; m > 0; m--) begin
      apb(1, ienc_pkg::OFS_CTRL, 32'(m));
      apb(0, ienc_pkg::OFS_CTRL, 0);
      chk("mode", 32'(m), rd & 32'h7);
    end
    for (int i = 0; i < 4; i++) begin
      apb(0, ienc_pkg::OFS_ALSTATE, 0);
      chk("state", 32'h1 << i, rd);
      if (i < 3) apb(1, ienc_pkg::OFS_ALSTATE, 32'h1);
    end
    apb(0, ienc_pkg::OFS_RELOAD, 0);
    chk("reload", 32'hffff, rd);
    apb(1, ienc_pkg::OFS_RELOAD, 32'h3);
    apb(0, ienc_pkg::OFS_RELOAD, 0);
    chk("reload", 32'h3, rd);
    mv(4, 1);
    chk("wrap", 32'h0, {16'h0, position});
    mv(1, 0);
    chk("under", 32'h3, {16'h0, position});
    apb(1, ienc_pkg::OFS_CTRL, 32'h11);
    apb(0, ienc_pkg::OFS_LATCH, 0);
    chk("latch", 32'h3, rd);
    chk("latch_pos", 32'h3, {16'h0, latch_pos});
    apb(0, ienc_pkg::OFS_CYCLIC0, 0);
    chk("cyclic0", 32'h0300_0301, rd);
    apb(0, ienc_pkg::OFS_CYCLIC1, 0);
    chk("cyclic1", 32'h0000_0000, rd);
    mv(8, 1, 199);
    chk("period", 32'd20, {16'h0, meas.period}, 1);
    chk("window", 32'd3, {16'h0, meas.window}, 1);
    remode(32'h2);
    mv(3, 1);
    idx <= 1;
    @(posedge pclk) idx <= 0;
    repeat (4) @(posedge pclk);
    chk("index", 32'h0, {16'h0, position});
    mv(3, 0);
    chk("modulo", 32'hfffd, {16'h0, position});
    remode(32'h13);
    fwd <= 1;
    p = position;
    mv(3, 1);
    mv(1, 0);
    chk("fwd", {16'h0, p + 16'h2}, {16'h0, position});
    gate <= 1;
    mv(2, 1);
    chk("gate", {16'h0, p + 16'h2}, {16'h0, position});
    apb(0, ienc_pkg::OFS_STATUS, 0);
    chk("status", 32'hb, rd);
    remode(32'h4);
    apb(0, ienc_pkg::OFS_CYCLIC0, 0);
    chk("cyclic0", 32'hffff_0001, rd);
    apb(0, ienc_pkg::OFS_CYCLIC1, 0);
    chk("cyclic1", 32'h0000_fffd, rd);
    fwd <= 0;
    mv(1, 1);
    chk("word wrap", 32'h0, {16'h0, position});
    chk("freq", 32'h0, meas.freq);
    tally_and_finish();
  end
endmodule
`default_nettype wire
